// >>> inc/aluis_pkg.sv
// shared types and constants for the instruction subset datapath
// assumes a decoder upstream that presents one decoded instruction per cycle
package aluis_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned LIT6_W = 6;
  localparam int unsigned BIT_W = 3;
  localparam int unsigned NUM_PTR = 2;
  localparam int unsigned PTR_MSB = 15;
  localparam int unsigned NIB_MSB = 3;
  localparam int unsigned DEST_W_SEL = 0;
  localparam int unsigned DEST_F_SEL = 1;

  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic FLAG_RST = 1'b0;

  typedef enum logic [2:0] {
    op_pointer_add_literal,
    op_and_immediate,
    op_add_immediate,
    op_and_file_register,
    op_add_file_register,
    op_add_file_with_carry,
    op_arith_shift_right,
    op_bit_clear_file
  } aluis_op_t;

  typedef struct packed {
    aluis_op_t op;
    logic [7:0] lit;
    logic [5:0] lit6;
    logic [6:0] addr;
    logic dest;
    logic [2:0] bit_idx;
    logic ptr_sel;
    logic indirect;
    logic ind_sel;
  } aluis_instr_t;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
  } aluis_flags_t;

endpackage

// >>> rtl/aluis_core.sv
// execution datapath for a subset of an 8-bit instruction set
// assumes file read data is valid for i_instr.addr in the accepting cycle
`timescale 1ns/10ps
module aluis_core
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // decoded instruction
  input wire logic i_valid,
  input wire aluis_pkg::aluis_instr_t i_instr,
  input wire logic [7:0] i_file_data,
  output logic o_ready,
  output logic o_done,
  // file register write port
  output logic o_file_we,
  output logic [6:0] o_file_addr,
  output logic [7:0] o_file_wdata,
  // architectural state
  output logic [7:0] o_wreg,
  output logic [15:0] o_ptr0,
  output logic [15:0] o_ptr1,
  output aluis_pkg::aluis_flags_t o_flags
);

  // carry out of bit 7, carry out of bit 3, sum
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  function automatic logic [15:0] sext6(input logic [5:0] k);
    return {{10{k[5]}}, k};
  endfunction

  logic [7:0] wreg_r, wreg_nxt;
  logic [15:0] ptr_r [aluis_pkg::NUM_PTR];
  logic [15:0] ptr_nxt [aluis_pkg::NUM_PTR];
  aluis_pkg::aluis_flags_t flags_r, flags_nxt;
  logic stall_r, stall_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic fwe_r, fwe_nxt;
  logic [6:0] faddr_r, faddr_nxt;
  logic [7:0] fwdata_r, fwdata_nxt;
  aluis_pkg::aluis_instr_t hold_r, hold_nxt;
  logic [7:0] hold_fd_r, hold_fd_nxt;
  logic [7:0] res_r, res_nxt;

  aluis_pkg::aluis_instr_t ex;
  logic [7:0] fd;
  logic accept, need_stall, ex_go;
  logic [9:0] sum;
  logic [7:0] res;
  logic to_wreg, to_file;
  logic [15:0] ptr_chk;

  assign accept = i_valid && ready_r;
  assign need_stall = i_instr.indirect &&
                      ptr_r[i_instr.ind_sel][aluis_pkg::PTR_MSB];
  assign ex_go = (accept && !need_stall) || stall_r;
  assign ex = stall_r ? hold_r : i_instr;
  assign fd = stall_r ? hold_fd_r : i_file_data;
  assign ptr_chk = ptr_r[ex.ptr_sel] + sext6(ex.lit6);

  always_comb
  begin
    wreg_nxt = wreg_r;
    ptr_nxt = ptr_r;
    flags_nxt = flags_r;
    fwe_nxt = 1'b0;
    faddr_nxt = faddr_r;
    fwdata_nxt = fwdata_r;
    res_nxt = res_r;
    sum = 10'h000;
    res = 8'h00;
    to_wreg = 1'b0;
    to_file = 1'b0;
    if (ex_go)
    begin
      unique case (ex.op)
        aluis_pkg::op_pointer_add_literal:
        begin
          ptr_nxt[ex.ptr_sel] = ptr_r[ex.ptr_sel] + sext6(ex.lit6);
        end
        aluis_pkg::op_and_immediate:
        begin
          res = wreg_r & ex.lit;
          flags_nxt.zero = (res == 8'h00);
          to_wreg = 1'b1;
        end
        aluis_pkg::op_add_immediate:
        begin
          sum = add8(wreg_r, ex.lit, 1'b0);
          res = sum[7:0];
          flags_nxt = {sum[9], sum[8], res == 8'h00};
          to_wreg = 1'b1;
        end
        aluis_pkg::op_and_file_register:
        begin
          res = wreg_r & fd;
          flags_nxt.zero = (res == 8'h00);
          to_wreg = (ex.dest == 1'(aluis_pkg::DEST_W_SEL));
          to_file = !to_wreg;
        end
        aluis_pkg::op_add_file_register:
        begin
          sum = add8(wreg_r, fd, 1'b0);
          res = sum[7:0];
          flags_nxt = {sum[9], sum[8], res == 8'h00};
          to_wreg = (ex.dest == 1'(aluis_pkg::DEST_W_SEL));
          to_file = !to_wreg;
        end
        aluis_pkg::op_add_file_with_carry:
        begin
          sum = add8(wreg_r, fd, flags_r.carry);
          res = sum[7:0];
          flags_nxt = {sum[9], sum[8], res == 8'h00};
          to_wreg = (ex.dest == 1'(aluis_pkg::DEST_W_SEL));
          to_file = !to_wreg;
        end
        aluis_pkg::op_arith_shift_right:
        begin
          res = {fd[7], fd[7:1]};
          flags_nxt.carry = fd[0];
          flags_nxt.zero = (res == 8'h00);
          to_wreg = (ex.dest == 1'(aluis_pkg::DEST_W_SEL));
          to_file = !to_wreg;
        end
        aluis_pkg::op_bit_clear_file:
        begin
          res = fd & ~(8'h01 << ex.bit_idx);
          to_file = 1'b1;
        end
      endcase
      if (to_wreg)
        wreg_nxt = res;
      if (to_file)
      begin
        fwe_nxt = 1'b1;
        faddr_nxt = ex.addr;
        fwdata_nxt = res;
      end
      res_nxt = res;
    end
  end

  always_comb
  begin
    stall_nxt = 1'b0;
    ready_nxt = 1'b1;
    hold_nxt = hold_r;
    hold_fd_nxt = hold_fd_r;
    done_nxt = ex_go;
    if (accept && need_stall)
    begin
      stall_nxt = 1'b1;
      ready_nxt = 1'b0;
      hold_nxt = i_instr;
      hold_fd_nxt = i_file_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wreg_r <= aluis_pkg::WREG_RST;
      ptr_r[0] <= aluis_pkg::PTR_RST;
      ptr_r[1] <= aluis_pkg::PTR_RST;
      flags_r <= {3{aluis_pkg::FLAG_RST}};
      stall_r <= 1'b0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      fwe_r <= 1'b0;
      faddr_r <= 7'h00;
      fwdata_r <= 8'h00;
      hold_r <= '0;
      hold_fd_r <= 8'h00;
      res_r <= 8'h00;
    end
    else
    begin
      wreg_r <= wreg_nxt;
      ptr_r <= ptr_nxt;
      flags_r <= flags_nxt;
      stall_r <= stall_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      fwe_r <= fwe_nxt;
      faddr_r <= faddr_nxt;
      fwdata_r <= fwdata_nxt;
      hold_r <= hold_nxt;
      hold_fd_r <= hold_fd_nxt;
      res_r <= res_nxt;
    end
  end

  assign o_ready = ready_r;
  assign o_done = done_r;
  assign o_file_we = fwe_r;
  assign o_file_addr = faddr_r;
  assign o_file_wdata = fwdata_r;
  assign o_wreg = wreg_r;
  assign o_ptr0 = ptr_r[0];
  assign o_ptr1 = ptr_r[1];
  assign o_flags = flags_r;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  sequence s_slow_take;
    accept && need_stall;
  endsequence
  sequence s_slow_finish;
    !o_ready && !o_done ##1 o_ready && o_done;
  endsequence

  a_ptr_add_wrap: assert property (
    ex_go && ex.op == aluis_pkg::op_pointer_add_literal
    |=> ($past(ex.ptr_sel) ? o_ptr1 : o_ptr0) == $past(ptr_chk)
        && o_flags == $past(o_flags))
    else $error("pointer add result wrong");
  a_and_imm_zero: assert property (
    ex_go && ex.op == aluis_pkg::op_and_immediate
    |=> o_wreg == ($past(o_wreg) & $past(ex.lit))
        && o_flags.zero == (o_wreg == 8'h00)
        && o_flags.carry == $past(o_flags.carry)
        && o_flags.digit_carry == $past(o_flags.digit_carry))
    else $error("and immediate wrong");
  a_add_imm_carry: assert property (
    ex_go && ex.op == aluis_pkg::op_add_immediate
    |=> {o_flags.carry, o_wreg} == {1'b0, $past(o_wreg)} + {1'b0, $past(ex.lit)})
    else $error("add immediate sum or carry wrong");
  a_file_dest_sel: assert property (
    ex_go && ex.op != aluis_pkg::op_pointer_add_literal
    && ex.op != aluis_pkg::op_and_immediate
    && ex.op != aluis_pkg::op_add_immediate
    |=> (o_file_we == ($past(ex.dest) || $past(ex.op) ==
         aluis_pkg::op_bit_clear_file))
        && (o_file_we ? o_file_addr == $past(ex.addr)
            && o_wreg == $past(o_wreg) : o_wreg == res_r))
    else $error("destination select wrong");
  a_carry_add_sum: assert property (
    ex_go && ex.op == aluis_pkg::op_add_file_with_carry
    |=> {o_flags.carry, res_r} == {1'b0, $past(o_wreg)} + {1'b0, $past(fd)}
        + {8'h00, $past(o_flags.carry)})
    else $error("add with carry wrong");
  a_shift_keep_msb: assert property (
    ex_go && ex.op == aluis_pkg::op_arith_shift_right
    |=> res_r[7] == $past(fd[7]) && res_r[6:0] == $past(fd[7:1])
        && o_flags.carry == $past(fd[0]))
    else $error("arithmetic shift wrong");
  a_bit_clear_only: assert property (
    ex_go && ex.op == aluis_pkg::op_bit_clear_file
    |=> o_file_we && o_file_wdata[$past(ex.bit_idx)] == 1'b0
        && (o_file_wdata | (8'h01 << $past(ex.bit_idx))) ==
           ($past(fd) | (8'h01 << $past(ex.bit_idx)))
        && o_flags == $past(o_flags))
    else $error("bit clear wrong");
  a_zero_digit_flag: assert property (
    ex_go && ex.op == aluis_pkg::op_add_file_register
    |=> o_flags.zero == (res_r == 8'h00)
        && o_flags.digit_carry == ({1'b0, $past(o_wreg[3:0])}
           + {1'b0, $past(fd[3:0])} > 5'h0F))
    else $error("zero or digit carry flag wrong");
  a_slow_one_extra: assert property (
    s_slow_take |=> s_slow_finish)
    else $error("indirect stall not exactly one cycle");

endmodule

// >>> verification/aluis_core_tb.sv
// self-checking bench for the instruction subset datapath
// assumes the bench plays decoder and file memory on its own
`timescale 1ns/10ps
module aluis_core_tb;
  typedef struct packed {
    logic [7:0] w;
    logic [15:0] p0;
    logic [15:0] p1;
    aluis_pkg::aluis_flags_t fl;
    logic we;
    logic [6:0] ad;
    logic [7:0] wd;
    logic [1:0] lat;
  } aluis_note_t;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic i_valid = 1'b0;
  aluis_pkg::aluis_instr_t i_instr = '0;
  logic [7:0] i_file_data = 8'h00;
  logic o_ready, o_done, o_file_we, rdy_smp;
  logic [6:0] o_file_addr;
  logic [7:0] o_file_wdata, o_wreg, m_w;
  logic [15:0] o_ptr0, o_ptr1;
  logic [15:0] m_p [2];
  logic [7:0] mem [128];
  aluis_pkg::aluis_flags_t o_flags, m_f;
  aluis_note_t nq [$];
  int tq [$];
  int cyc = 0;
  int err_total = 0;
  int compares = 0;
  integer seed = 32'hDE30;
  aluis_core i_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_valid(i_valid), .i_instr(i_instr), .i_file_data(i_file_data),
    .o_ready(o_ready), .o_done(o_done), .o_file_we(o_file_we),
    .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata),
    .o_wreg(o_wreg), .o_ptr0(o_ptr0), .o_ptr1(o_ptr1), .o_flags(o_flags));
  always #2 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) rdy_smp = o_ready;
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // reference model notes the result, then presents until taken
  task automatic exec(input aluis_pkg::aluis_instr_t ins);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] f, b, r;
    logic ci;
    aluis_note_t n;
    f = mem[ins.addr];
    n = '0;
    r = 8'h00;
    n.lat = (ins.indirect && m_p[ins.ind_sel][15]) ? 2'h2 : 2'h1;
    case (ins.op)
      aluis_pkg::op_pointer_add_literal: m_p[ins.ptr_sel] =
        m_p[ins.ptr_sel] + {{10{ins.lit6[5]}}, ins.lit6};
      aluis_pkg::op_and_immediate: r = m_w & ins.lit;
      aluis_pkg::op_and_file_register: r = m_w & f;
      aluis_pkg::op_arith_shift_right:
      begin
        r = {f[7], f[7:1]};
        m_f.carry = f[0];
      end
      aluis_pkg::op_bit_clear_file:
      begin
        r = f;
        r[ins.bit_idx] = 1'b0;
      end
      // carries from bits 7 and 3
      default:
      begin
        b = (ins.op == aluis_pkg::op_add_immediate) ? ins.lit : f;
        ci = (ins.op == aluis_pkg::op_add_file_with_carry) & m_f.carry;
        s = m_w + b + ci;
        h = m_w[3:0] + b[3:0] + ci;
        r = s[7:0];
        m_f.carry = s[8];
        m_f.digit_carry = h[4];
      end
    endcase
    if (ins.op != aluis_pkg::op_pointer_add_literal)
    begin
      if (ins.op != aluis_pkg::op_bit_clear_file)
        m_f.zero = (r == 8'h00);
      // destination bit picks file or accumulator
      if (ins.op == aluis_pkg::op_and_immediate ||
          ins.op == aluis_pkg::op_add_immediate)
        m_w = r;
      else if (ins.op == aluis_pkg::op_bit_clear_file || ins.dest)
      begin
        n.we = 1'b1;
        mem[ins.addr] = r;
      end
      else
        m_w = r;
    end
    n.ad = ins.addr;
    n.wd = r;
    n.w = m_w;
    n.p0 = m_p[0];
    n.p1 = m_p[1];
    n.fl = m_f;
    nq.push_back(n);
    i_instr <= ins;
    i_file_data <= f;
    i_valid <= 1'b1;
    do @(posedge i_clk_sys); while (rdy_smp !== 1'b1);
  endtask
  function automatic aluis_pkg::aluis_instr_t rnd(input int op);
    logic [31:0] rv;
    aluis_pkg::aluis_instr_t ins;
    rv = $random(seed);
    ins = rv[30:0];
    if (op >= 0)
      ins.op = aluis_pkg::aluis_op_t'(op);
    return ins;
  endfunction
  always @(posedge i_clk_sys)
  begin
    aluis_note_t n;
    int t;
    if (i_rstn)
    begin
      if (i_valid && o_ready === 1'b1)
        tq.push_back(cyc);
      if (o_done === 1'b1 && nq.size() > 0 && tq.size() > 0)
      begin
        n = nq.pop_front();
        t = tq.pop_front();
        chk("latency", 16'(n.lat), 16'(cyc - t));
        chk("wreg", n.w, o_wreg);
        chk("ptr0", n.p0, o_ptr0);
        chk("ptr1", n.p1, o_ptr1);
        chk("flags", n.fl, o_flags);
        chk("file_we", n.we, o_file_we);
        if (n.we)
        begin
          chk("file_addr", n.ad, o_file_addr);
          chk("file_wdata", n.wd, o_file_wdata);
        end
      end
      else
        chk("idle_we", 1'b0, o_file_we);
    end
    cyc++;
  end
  initial
  begin
    #80000;
    err_total++;
    results();
  end
  initial
  begin
    aluis_pkg::aluis_instr_t ins;
    logic [5:0] k6 [4];
    logic [7:0] k8 [3];
    m_w = 8'h00;
    m_f = '0;
    m_p[0] = 16'h0000;
    m_p[1] = 16'h0000;
    for (int a = 0; a < 128; a++)
      mem[a] = $random(seed);
    repeat (8) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    chk("reset", 16'h1000, {3'h0, o_ready, o_done, o_wreg, o_flags});
    chk("reset_ptr", 16'h0000, o_ptr0 | o_ptr1);
    $display("test reset done");
    @(posedge i_clk_sys);
    // pointer wrap both ways, stalling on the two adds made while the pointer is high
    k6 = '{6'h20, 6'h1F, 6'h01, 6'h20};
    k8 = '{8'h00, 8'hFF, 8'h01};
    foreach (k6[k])
    begin
      ins = rnd(0);
      ins.ptr_sel = 1'b0;
      ins.lit6 = k6[k];
      ins.indirect = 1'b1;
      ins.ind_sel = 1'b0;
      exec(ins);
    end
    foreach (k8[k])
    begin
      ins = rnd(k == 0 ? 1 : 2);
      ins.lit = k8[k];
      exec(ins);
    end
    $display("test boundaries done");
    for (int op = 0; op < 8; op++)
      for (int d = 0; d < 2; d++)
      begin
        ins = rnd(op);
        ins.dest = d[0];
        ins.indirect = 1'b1;
        exec(ins);
      end
    $display("test every op done");
    for (int k = 0; k < 400; k++)
    begin
      exec(rnd(-1));
      if ($random(seed) % 4 == 0)
      begin
        i_valid <= 1'b0;
        @(posedge i_clk_sys);
      end
    end
    i_valid <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    chk("pending", 16'h0000, 16'(nq.size()));
    $display("test random done");
    results();
  end
endmodule
